// [src/touch_slider_control.sv]
// Control, reporting and calibration sequencing of the touch slider
//
// How it works
// - After a frame held low 35 us past the last clock, the block sleeps until slave select rises.
// - On wake the prox, touch and ready pins float about 400 us.
// - On wake the block pulls slave select low for 250 ns.
// - Prox pin goes high when a hand is sensed near the strip.
// - Without touch, prox shows in bit 0 of the response byte.
// - Touch pin goes high when the signal allows a position.
// - Touch shows in bit 7 of the response byte.
// - Host sets prox and touch thresholds by command; both apply.
// - Position is reported only while touched.
// - Position is 7 bits unsigned, 0 left, 127 right.
// - Position updates on a brief touch and tracks a slide.
// - Position reporting stops when touch is lost.
// - A baseline calibration runs at every power-up.
// - Command 0x01 starts a baseline calibration any time.
// - Calibration is ten bursts, 2 ms apart, self-run.
// - Untouched, bit 1 flags a signal well below the baseline.
// - Calibrated with a hand near, the flag sets once withdrawn.
// - Reference follows drift only on the drift command.
// - After wake, wait 500 us before a burst.
// - No settling wait when no sleep came before the burst.
// - Ready pin goes high when the host may communicate.
// - Each fall and rise of slave select gives one burst.
// - Slave select held high gives a burst every 60 ms.
`timescale 1ns/1ps
`include "touch_slider_regs.svh"
module touch_slider_control #(
    parameter int FloatCyc = `FLOAT_CYC,
    parameter int SettleCyc = `SETTLE_CYC,
    parameter int CalGapCyc = `CAL_GAP_CYC,
    parameter int FreeRunCyc = `FREE_RUN_CYC,
    parameter int QuietCyc = `QUIET_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic ssIn,
    output logic ssOut,
    output logic ssOeN,
    input wire logic sclkIn,
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic [7:0] cmdData,
    output logic burstStart,
    input wire logic burstDone,
    input wire logic [15:0] sigLevel,
    input wire logic [6:0] posRaw,
    output logic proxOut,
    output logic proxOeN,
    output logic touchOut,
    output logic touchOeN,
    output logic commAllowedOut,
    output logic commAllowedOeN,
    output logic [7:0] respByte,
    output logic [6:0] position,
    output logic endCalArmed,
    output logic calibrating
);
    localparam int DiagCyc = `DIAG_CYC;
    localparam touch_slider_pkg::state_t RstSt = '{
        state: touch_slider_pkg::IDLE,
        ssMeta: 1'b1,
        ssSync: 1'b1,
        ssPrev: 1'b1,
        sclkMeta: 1'b1,
        sclkSync: 1'b1,
        sclkPrev: 1'b1,
        calLeft: `CAL_BURSTS,
        calBusy: 1'b1,
        proxTh: `PROX_TH_RST,
        touchTh: `TOUCH_TH_RST,
        pinOeN: 1'b1,
        ssOeN: 1'b1,
        default: '0
    };

    touch_slider_pkg::state_t st_ff;
    touch_slider_pkg::state_t nxt_st;
    logic ssRise;
    logic ssFall;
    logic sclkRise;
    logic timerEnd;
    logic [16:0] touchLvl;
    logic [16:0] proxLvl;
    logic [16:0] errLvl;
    logic isTouch;

    assign ssRise = st_ff.ssSync & ~st_ff.ssPrev;
    assign ssFall = ~st_ff.ssSync & st_ff.ssPrev;
    assign sclkRise = st_ff.sclkSync & ~st_ff.sclkPrev;
    assign touchLvl = {1'b0, st_ff.base} + {9'h000, st_ff.touchTh};
    assign proxLvl = {1'b0, st_ff.base} + {9'h000, st_ff.proxTh};
    assign errLvl = {1'b0, sigLevel} + {1'b0, `ERR_MARGIN};
    assign isTouch = {1'b0, sigLevel} >= touchLvl;

    always_comb
    begin
        nxt_st = st_ff;
        timerEnd = 1'b0;
        nxt_st.ssMeta = ssIn;
        nxt_st.ssSync = st_ff.ssMeta;
        nxt_st.ssPrev = st_ff.ssSync;
        nxt_st.sclkMeta = sclkIn;
        nxt_st.sclkSync = st_ff.sclkMeta;
        nxt_st.sclkPrev = st_ff.sclkSync;
        nxt_st.timer = st_ff.timer + 24'h000001;
        nxt_st.burstStart = 1'b0;
        nxt_st.ssOeN = 1'b1;
        if (st_ff.floatCnt != 17'h00000)
            nxt_st.floatCnt = st_ff.floatCnt - 17'h00001;
        // Host commands from the serial decoder
        if (cmdValid)
        begin
            nxt_st.lastCal = (cmdCode == `CMD_CAL);
            unique case (cmdCode)
                `CMD_CAL:
                begin
                    nxt_st.calLeft = `CAL_BURSTS;
                    nxt_st.endCal = 1'b0;
                end
                `CMD_END_CAL:
                    nxt_st.endCal = st_ff.lastCal;
                `CMD_DRIFT:
                begin
                    // One count toward the last untouched signal
                    if (st_ff.lastSig > st_ff.base)
                        nxt_st.base = st_ff.base + 16'h0001;
                    else if (st_ff.lastSig < st_ff.base)
                        nxt_st.base = st_ff.base - 16'h0001;
                end
                `CMD_PROX_TH:
                    nxt_st.proxTh = cmdData;
                `CMD_TOUCH_TH:
                    nxt_st.touchTh = cmdData;
                default:
                    nxt_st.lastCal = 1'b0;
            endcase
        end
        // Results of a finished burst
        if (burstDone && st_ff.state == touch_slider_pkg::BURST)
        begin
            if (st_ff.calLeft != 4'h0)
            begin
                // A fresh calibration command restarts the count
                if (!(cmdValid && cmdCode == `CMD_CAL))
                    nxt_st.calLeft = st_ff.calLeft - 4'h1;
                if (st_ff.calLeft == 4'h1)
                    nxt_st.base = sigLevel;
                nxt_st.touch = 1'b0;
                nxt_st.prox = 1'b0;
                nxt_st.err = 1'b0;
                nxt_st.pos = 7'h00;
            end
            else
            begin
                nxt_st.touch = isTouch;
                nxt_st.prox = {1'b0, sigLevel} >= proxLvl;
                // Hand gone after a bad calibration drops below base
                nxt_st.err = !isTouch &&
                    errLvl < {1'b0, st_ff.base};
                // Fresh on every touched burst, zero once released
                nxt_st.pos = isTouch ? posRaw : 7'h00;
                if (!isTouch)
                    nxt_st.lastSig = sigLevel;
            end
        end
        nxt_st.resp = 8'h00;
        nxt_st.resp[`RESP_TOUCH_BIT] = nxt_st.touch;
        nxt_st.resp[`RESP_PROX_BIT] = nxt_st.prox & ~nxt_st.touch;
        nxt_st.resp[`RESP_ERR_BIT] = nxt_st.err & ~nxt_st.touch;
        unique case (st_ff.state)
            touch_slider_pkg::IDLE:
            begin
                timerEnd = st_ff.timer == 24'(FreeRunCyc - 1);
                if (ssFall)
                begin
                    nxt_st.state = touch_slider_pkg::FRAME;
                    nxt_st.timer = 24'h000000;
                end
                else if (st_ff.calLeft != 4'h0 || timerEnd)
                begin
                    nxt_st.state = touch_slider_pkg::BURST;
                    nxt_st.burstStart = 1'b1;
                end
            end
            touch_slider_pkg::FRAME:
            begin
                if (sclkRise)
                    nxt_st.timer = 24'h000000;
                if (ssRise)
                begin
                    // No sleep came first, so no settling wait
                    nxt_st.state = touch_slider_pkg::BURST;
                    nxt_st.burstStart = 1'b1;
                end
                else if (st_ff.timer == 24'(QuietCyc - 1))
                    nxt_st.state = touch_slider_pkg::SLEEP;
            end
            touch_slider_pkg::SLEEP:
            begin
                if (ssRise)
                begin
                    nxt_st.state = touch_slider_pkg::DIAG;
                    nxt_st.timer = 24'h000000;
                    nxt_st.floatCnt = 17'(FloatCyc);
                    nxt_st.ssOeN = 1'b0;
                end
            end
            touch_slider_pkg::DIAG:
            begin
                // Slave select is ignored while we pull it low
                if (st_ff.timer == 24'(DiagCyc - 1))
                begin
                    nxt_st.state = touch_slider_pkg::SETTLE;
                    nxt_st.timer = 24'h000000;
                end
                else
                    nxt_st.ssOeN = 1'b0;
            end
            touch_slider_pkg::SETTLE:
            begin
                if (st_ff.timer == 24'(SettleCyc - 1))
                begin
                    nxt_st.state = touch_slider_pkg::BURST;
                    nxt_st.burstStart = 1'b1;
                end
            end
            touch_slider_pkg::BURST:
            begin
                nxt_st.timer = 24'h000000;
                if (burstDone)
                begin
                    if (st_ff.calLeft > 4'h1)
                        nxt_st.state = touch_slider_pkg::CALGAP;
                    else if (!st_ff.ssSync)
                        nxt_st.state = touch_slider_pkg::FRAME;
                    else
                        nxt_st.state = touch_slider_pkg::IDLE;
                end
            end
            touch_slider_pkg::CALGAP:
            begin
                if (st_ff.timer == 24'(CalGapCyc - 1))
                begin
                    nxt_st.state = touch_slider_pkg::BURST;
                    nxt_st.burstStart = 1'b1;
                end
            end
        endcase
        nxt_st.pinOeN = nxt_st.floatCnt != 17'h00000;
        nxt_st.calBusy = nxt_st.calLeft != 4'h0;
        nxt_st.ready = (nxt_st.state == touch_slider_pkg::IDLE ||
            nxt_st.state == touch_slider_pkg::FRAME) &&
            nxt_st.calLeft == 4'h0;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            st_ff <= RstSt;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign ssOut = 1'b0 & st_ff.ssOeN;
    assign ssOeN = st_ff.ssOeN;
    assign burstStart = st_ff.burstStart;
    assign proxOut = st_ff.prox;
    assign proxOeN = st_ff.pinOeN;
    assign touchOut = st_ff.touch;
    assign touchOeN = st_ff.pinOeN;
    assign commAllowedOut = st_ff.ready;
    assign commAllowedOeN = st_ff.pinOeN;
    assign respByte = st_ff.resp;
    assign position = st_ff.pos;
    assign endCalArmed = st_ff.endCal;
    assign calibrating = st_ff.calBusy;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence wakeSeq;
        st_ff.state == touch_slider_pkg::SLEEP && ssRise;
    endsequence
    sequence doneSeq;
        st_ff.state == touch_slider_pkg::BURST && burstDone;
    endsequence

    chk_sleep_hold: assert property (
        st_ff.state == touch_slider_pkg::SLEEP && !ssRise |=>
        st_ff.state == touch_slider_pkg::SLEEP && !burstStart)
        else $error("left sleep without slave select rise");
    chk_wake_float: assert property (
        wakeSeq |=> (proxOeN && touchOeN && commAllowedOeN) [*8])
        else $error("pins driven during wake float");
    chk_diag_pulse: assert property (
        wakeSeq |=> !ssOeN [*8])
        else $error("slave select not pulled low on wake");
    chk_prox_set: assert property (
        doneSeq and ##0 st_ff.calLeft == 4'h0 &&
        {1'b0, sigLevel} >= proxLvl |=> proxOut)
        else $error("prox not raised above threshold");
    chk_resp_bits: assert property (
        respByte[7] == touchOut &&
        (!touchOut || respByte[1:0] == 2'b00))
        else $error("response byte disagrees with touch");
    chk_pos_touch: assert property (
        !touchOut |-> position == 7'h00)
        else $error("position reported without touch");
    chk_cal_cmd: assert property (
        cmdValid && cmdCode == `CMD_CAL |=> st_ff.calLeft == `CAL_BURSTS)
        else $error("calibration command not taken");
    chk_settle_wait: assert property (
        $rose(st_ff.state == touch_slider_pkg::SETTLE) |->
        !burstStart [*8])
        else $error("burst started during settle");
    chk_frame_burst: assert property (
        st_ff.state == touch_slider_pkg::FRAME && ssRise |=>
        burstStart && st_ff.state == touch_slider_pkg::BURST)
        else $error("no burst after frame");
    chk_drift_only: assert property (
        $changed(st_ff.base) |->
        $past(cmdValid && cmdCode == `CMD_DRIFT) ||
        $past(st_ff.calLeft == 4'h1 && burstDone))
        else $error("reference moved without a cause");
endmodule

// [src/touch_slider_regs.svh]
// Constants of the touch slider control block
`ifndef TOUCH_SLIDER_REGS_SVH
`define TOUCH_SLIDER_REGS_SVH
`define CLK_MHZ 250
`define FLOAT_US 400
`define SETTLE_US 500
`define DIAG_NS 250
`define CAL_GAP_MS 2
`define FREE_RUN_MS 60
`define QUIET_US 35
`define FLOAT_CYC (`FLOAT_US * `CLK_MHZ)
`define SETTLE_CYC (`SETTLE_US * `CLK_MHZ)
`define DIAG_CYC ((`DIAG_NS * `CLK_MHZ + 999) / 1000)
`define CAL_GAP_CYC (`CAL_GAP_MS * 1000 * `CLK_MHZ)
`define FREE_RUN_CYC (`FREE_RUN_MS * 1000 * `CLK_MHZ)
`define QUIET_CYC (`QUIET_US * `CLK_MHZ)
`define CAL_BURSTS 4'ha
`define CMD_CAL 8'h01
`define CMD_END_CAL 8'h02
`define CMD_DRIFT 8'h03
`define CMD_PROX_TH 8'h05
`define CMD_TOUCH_TH 8'h06
`define RESP_PROX_BIT 0
`define RESP_ERR_BIT 1
`define RESP_TOUCH_BIT 7
`define PROX_TH_RST 8'h10
`define TOUCH_TH_RST 8'h40
`define ERR_MARGIN 16'h0020
`endif

// [src/touch_slider_pkg.sv]
// Types of the touch slider control block
package touch_slider_pkg;
    typedef enum logic [5:0] {
        IDLE   = 6'h01,
        FRAME  = 6'h02,
        SLEEP  = 6'h04,
        DIAG   = 6'h08,
        SETTLE = 6'h10,
        BURST  = 6'h20,
        CALGAP = 6'h40
    } mode_t;
    typedef struct packed {
        mode_t state;
        logic ssMeta;
        logic ssSync;
        logic ssPrev;
        logic sclkMeta;
        logic sclkSync;
        logic sclkPrev;
        logic [23:0] timer;
        logic [16:0] floatCnt;
        logic [3:0] calLeft;
        logic lastCal;
        logic endCal;
        logic [15:0] base;
        logic [15:0] lastSig;
        logic [7:0] proxTh;
        logic [7:0] touchTh;
        logic prox;
        logic touch;
        logic err;
        logic [6:0] pos;
        logic [7:0] resp;
        logic burstStart;
        logic ready;
        logic calBusy;
        logic pinOeN;
        logic ssOeN;
    } state_t;
endpackage

// [sim/host_spi_model.sv]
// Host controller model driving slave select and the serial clock
`timescale 1ns/1ps
module host_spi_model (
    input wire logic ssOut,
    input wire logic ssOeN,
    output logic ssIn,
    output logic sclkIn
);
    logic hostLow;

    initial
    begin
        hostLow = 1'b0;
        sclkIn = 1'b1;
    end

    // Open drain with pull-up, so the block's clamp always wins
    assign ssIn = (ssOeN === 1'b0) ? ssOut : !hostLow;

    // Frame of n serial clocks at 80 ns, select then held low holdNs more
    // The float-time pins are never looked at by this host
    task automatic frame(input int n, input int holdNs);
        hostLow = 1'b1;
        #40;
        repeat (n)
        begin
            sclkIn = 1'b0;
            #40;
            sclkIn = 1'b1;
            #40;
        end
        #(holdNs);
        hostLow = 1'b0;
    endtask
endmodule

// [sim/tb_top.sv]
// Self-checking bench of the touch slider control block
`timescale 1ns/1ps
`include "touch_slider_regs.svh"
module tb_top;
    localparam int FloatCyc = 40;
    localparam int SettleCyc = 60;
    localparam int CalGapCyc = 20;
    localparam int FreeRunCyc = 200;
    localparam int QuietCyc = 30;
    localparam logic [15:0] Base = 16'h1000;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic cmdValid = 1'b0;
    logic [7:0] cmdCode = 8'h00;
    logic [7:0] cmdData = 8'h00;
    logic burstDone = 1'b0;
    logic [15:0] feSig = Base;
    logic [6:0] fePos = 7'h00;
    logic ssIn, ssOut, ssOeN, sclkIn, burstStart;
    logic proxOut, proxOeN, touchOut, touchOeN;
    logic commAllowedOut, commAllowedOeN, endCalArmed, calibrating;
    logic [7:0] respByte;
    logic [6:0] position;
    int n_mismatch = 0;
    int n_compared = 0;
    int nBurst = 0;
    int cyc = 0;
    int doneCyc = 0;
    int startCyc = 0;
    int calGap = 0;
    int period = 0;
    int diagCnt = 0;
    int wakeCyc = 0;
    int floatCnt = 0;

    always #2 clock = ~clock;

    touch_slider_control #(.FloatCyc(FloatCyc), .SettleCyc(SettleCyc),
        .CalGapCyc(CalGapCyc), .FreeRunCyc(FreeRunCyc),
        .QuietCyc(QuietCyc)) i_touch_slider_control (
        .clock(clock), .resetn(resetn), .ssIn(ssIn), .ssOut(ssOut),
        .ssOeN(ssOeN), .sclkIn(sclkIn), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdData(cmdData), .burstStart(burstStart),
        .burstDone(burstDone), .sigLevel(feSig), .posRaw(fePos),
        .proxOut(proxOut), .proxOeN(proxOeN), .touchOut(touchOut),
        .touchOeN(touchOeN), .commAllowedOut(commAllowedOut),
        .commAllowedOeN(commAllowedOeN), .respByte(respByte),
        .position(position), .endCalArmed(endCalArmed),
        .calibrating(calibrating));

    host_spi_model i_host_spi_model (.ssOut(ssOut), .ssOeN(ssOeN),
        .ssIn(ssIn), .sclkIn(sclkIn));

    // Timing monitor for bursts, clamp pulse and floating pins
    always @(posedge clock)
    begin
        cyc++;
        if (burstDone === 1'b1)
            doneCyc = cyc;
        if (burstStart === 1'b1)
        begin
            calGap = cyc - doneCyc;
            period = cyc - startCyc;
            startCyc = cyc;
        end
        if (ssOeN === 1'b0)
        begin
            if (diagCnt == 0)
                wakeCyc = cyc;
            diagCnt++;
        end
        if ((proxOeN & touchOeN & commAllowedOeN) === 1'b1)
            floatCnt++;
    end

    // Front end answers every burst request after a few cycles
    always @(posedge clock)
    begin
        if (burstStart === 1'b1)
        begin
            repeat (4) @(negedge clock);
            burstDone <= 1'b1;
            @(negedge clock);
            burstDone <= 1'b0;
            nBurst++;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] code, input logic [7:0] data);
        @(negedge clock);
        cmdValid <= 1'b1;
        cmdCode <= code;
        cmdData <= data;
        @(negedge clock);
        cmdValid <= 1'b0;
    endtask

    task automatic wait_burst();
        int n0;
        n0 = nBurst;
        for (int i = 0; i < 1000 && nBurst == n0; i++)
            @(negedge clock);
        check(16'(nBurst != n0), 16'h1);
        repeat (2) @(negedge clock);
    endtask

    task automatic kick();
        i_host_spi_model.frame(0, 0);
        wait_burst();
    endtask

    task automatic run_cal();
        for (int i = 1; i <= 10; i++)
        begin
            wait_burst();
            check(16'(calibrating), 16'(i < 10));
            if (i > 1)
            begin
                check(16'(calGap >= CalGapCyc), 16'h1);
                check(16'(calGap <= CalGapCyc + 4), 16'h1);
            end
        end
    endtask

    task automatic t_powerup();
        check(16'(calibrating), 16'h1);
        run_cal();
        check(16'(commAllowedOut), 16'h1);
        wait_burst();
        wait_burst();
        check(16'(period >= FreeRunCyc), 16'h1);
        check(16'(period <= FreeRunCyc + 10), 16'h1);
        $display("done powerup and free run");
    endtask

    task automatic t_frames();
        int t0;
        diagCnt = 0;
        i_host_spi_model.frame(2, 0);
        t0 = cyc;
        wait_burst();
        check(16'(startCyc - t0 <= 8), 16'h1);
        check(16'(diagCnt), 16'h0);
        kick();
        t0 = nBurst;
        diagCnt = 0;
        floatCnt = 0;
        i_host_spi_model.frame(2, 1200);
        check(16'(nBurst), 16'(t0));
        wait_burst();
        check(16'(diagCnt), 16'(`DIAG_CYC));
        check(16'(floatCnt), 16'(FloatCyc));
        t0 = startCyc - wakeCyc - `DIAG_CYC - SettleCyc;
        check(16'(t0 >= 0 && t0 <= 4), 16'h1);
        check(16'({commAllowedOut, commAllowedOeN}), 16'h2);
        $display("done frames and sleep");
    endtask

    task automatic t_touch();
        feSig = Base + 16'h0040;
        fePos = 7'h7f;
        kick();
        check(16'({proxOut, touchOut}), 16'h3);
        check(16'(respByte), 16'h80);
        check(16'(position), 16'h7f);
        fePos = 7'h00;
        kick();
        check(16'(position), 16'h0);
        fePos = 7'h2a;
        kick();
        check(16'(position), 16'h2a);
        feSig = Base + 16'h003f;
        kick();
        check(16'({proxOut, touchOut}), 16'h2);
        check(16'(position), 16'h0);
        check(16'(respByte), 16'h01);
        feSig = Base + 16'h000f;
        kick();
        check(16'({proxOut, respByte}), 16'h0);
        cmd(8'h06, 8'h20);
        cmd(8'h05, 8'h30);
        feSig = Base + 16'h0028;
        kick();
        check(16'({proxOut, touchOut}), 16'h1);
        cmd(8'h06, 8'h40);
        cmd(8'h05, 8'h10);
        $display("done touch and thresholds");
    endtask

    task automatic t_error();
        feSig = Base - 16'h0021;
        fePos = 7'h10;
        kick();
        check(16'(respByte), 16'h02);
        kick();
        check(16'(respByte), 16'h02);
        cmd(8'h03, 8'h00);
        kick();
        check(16'(respByte), 16'h0);
        $display("done error and drift");
    endtask

    task automatic t_hand_cal();
        feSig = Base + 16'h0030;
        @(negedge clock);
        cmdValid <= 1'b1;
        cmdCode <= 8'h01;
        @(negedge clock);
        cmdCode <= 8'h02;
        check(16'(calibrating), 16'h1);
        @(negedge clock);
        cmdValid <= 1'b0;
        @(negedge clock);
        check(16'(endCalArmed), 16'h1);
        check(16'(commAllowedOut), 16'h0);
        run_cal();
        feSig = Base;
        kick();
        check(16'(respByte), 16'h02);
        // Clean recalibration with no hand near
        cmd(8'h01, 8'h00);
        run_cal();
        kick();
        check(16'(respByte), 16'h0);
        $display("done calibration with hand");
    endtask

    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        #100000;
        n_mismatch++;
        final_report();
    end

    initial
    begin
        repeat (10) @(negedge clock);
        resetn <= 1'b1;
        t_powerup();
        t_frames();
        t_touch();
        t_error();
        t_hand_cal();
        final_report();
    end
endmodule
